// >>> src/vcfd_defines.svh
// Constants of the voice-coil focus driver control block
`ifndef VCFD_DEFINES_SVH
`define VCFD_DEFINES_SVH

// Clock and timing
`define VCFD_CLK_NS        40
`define VCFD_CLK_KHZ       25000
`define VCFD_CLK_LOW_US    500
`define VCFD_CLK_LOW_CYC   ((`VCFD_CLK_LOW_US * 1000 + `VCFD_CLK_NS - 1) / `VCFD_CLK_NS)
`define VCFD_PWM_MIN_KHZ   500
`define VCFD_RES_MIN_HZ    50
`define VCFD_RES_MAX_HZ    150
`define VCFD_RAMP_STEPS    16
`define VCFD_RAMP_SHIFT    4
`define VCFD_RAMP_LAST     5'h10
`define VCFD_RAMP_STEP_MAX (1000000000 / (`VCFD_RES_MIN_HZ * `VCFD_RAMP_STEPS * `VCFD_CLK_NS))
`define VCFD_RAMP_STEP_MIN (1000000000 / (`VCFD_RES_MAX_HZ * `VCFD_RAMP_STEPS * `VCFD_CLK_NS))
`define VCFD_RAMP_SLOPE    ((`VCFD_RAMP_STEP_MAX - `VCFD_RAMP_STEP_MIN) / 255)
`define VCFD_CODE_SHIFT    10

// Register offsets
`define VCFD_OFS_CONTROL   8'h02
`define VCFD_OFS_MODE      8'h03
`define VCFD_OFS_CODE      8'h04
`define VCFD_OFS_STATUS    8'h05
`define VCFD_OFS_RES       8'h07

// Field positions
`define VCFD_CTL_SRST_BIT  0
`define VCFD_CTL_RATE_LSB  1
`define VCFD_CTL_RATE_MSB  3
`define VCFD_MODE_PWM_BIT  0
`define VCFD_MODE_ONEP_BIT 1

// Reset values
`define VCFD_DEF_CODE      10'h000
`define VCFD_DEF_RES       8'h00
`define VCFD_DEF_RATE      3'h0
`define VCFD_DEF_PWM       1'b0
`define VCFD_DEF_ONEP      1'b0

`endif

// >>> src/vcfd_pkg.sv
// Types of the voice-coil focus driver control block
package vcfd_pkg;

  typedef enum logic [1:0]
  {
    VCFD_SHUTDOWN = 2'b00,
    VCFD_STANDBY  = 2'b01,
    VCFD_ACTIVE   = 2'b11
  } vcfd_state_t;

  typedef struct packed
  {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } vcfd_bus_t;

  typedef struct packed
  {
    logic overheat_fault;
    logic coil_short_fault;
    logic coil_open_fault;
  } vcfd_fault_t;

endpackage

// >>> src/vcfd_ctrl.sv
// Voice-coil focus driver control: power states, registers, ramp and output stage
//
// Functional notes
// - Serial clock low for the timeout sends the device to shutdown.
// - Rising serial clock in shutdown gives standby with default registers.
// - Nonzero coil current code puts device active with stage enabled.
// - Every new code moves the coil current along a stepped ramp.
// - One mode bit picks linear or PWM coil drive.
// - PWM switching rate set by control field, 0.5 to 4 MHz.
// - Linear drive holds high side as current source at the code.
// - PWM period: high side on first, then low side freewheel.
// - Host clocks at most 400 kHz; register writes are ignored in shutdown.
// - Ramp length follows 50-150 Hz resonance, one or two periods.
// - Drive style changes only at PWM period boundary, current continuous.
// - Fault while active drops to standby and clears the code.
// - Soft reset bit while active gives standby and default registers.
// - Resonance setting is an 8-bit register at address 07h.
// - Coil target is a 10-bit code driving the reference converter.
`timescale 1ns/1ps
`include "vcfd_defines.svh"

module vcfd_ctrl #(
  parameter int unsigned CLK_LOW_CYC   = `VCFD_CLK_LOW_CYC,
  parameter int unsigned RAMP_STEP_MAX = `VCFD_RAMP_STEP_MAX,
  parameter int unsigned RAMP_SLOPE    = `VCFD_RAMP_SLOPE
) (
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  input  wire logic                 scl_in,
  input  wire vcfd_pkg::vcfd_bus_t  bus,
  input  wire vcfd_pkg::vcfd_fault_t faults,
  output logic [15:0]               rd_data,
  output logic [9:0]                coil_dac_code,
  output logic                      stage_en,
  output logic                      hs_gate,
  output logic                      ls_gate,
  output logic                      lin_drive,
  output vcfd_pkg::vcfd_state_t     power_state
);

  vcfd_pkg::vcfd_state_t state_reg;
  logic [3:0]  sync1_reg;
  logic [3:0]  sync2_reg;
  logic        scl_d_reg;
  logic [15:0] low_cnt_reg;
  logic        low_hit;
  logic        scl_rise;
  logic [2:0]  fault_s;
  logic        fault_act;
  logic        srst_req;
  logic        wr_ok;
  logic        load_def;
  logic [9:0]  code_reg;
  logic [7:0]  res_reg;
  logic [2:0]  rate_reg;
  logic        pwm_sel_reg;
  logic        onep_reg;
  logic [2:0]  status_reg;
  logic [15:0] rd_data_reg;
  logic [9:0]  start_reg;
  logic [9:0]  target_reg;
  logic [9:0]  drive_reg;
  logic [4:0]  idx_reg;
  logic [17:0] tick_reg;
  logic [17:0] step_len;
  logic        ramp_new;
  logic [9:0]  drive_next;
  logic [5:0]  pwm_cnt_reg;
  logic [5:0]  period;
  logic [5:0]  on_cnt_reg;
  logic        pwm_lat_reg;
  logic        lin_reg;
  logic        pwm_wrap;
  logic        stage_en_reg;
  logic        hs_reg;
  logic        ls_reg;

  // Pin inputs: serial clock and fault flags, two flops each
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_reg <= 4'h8; // Serial clock idles high, no false edge
      sync2_reg <= 4'h8;
      scl_d_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= {scl_in, faults};
      sync2_reg <= sync1_reg;
      scl_d_reg <= sync2_reg[3];
    end
  end

  assign fault_s  = sync2_reg[2:0];
  assign scl_rise = sync2_reg[3] && !scl_d_reg;
  assign low_hit  = !sync2_reg[3] && (low_cnt_reg == 16'(CLK_LOW_CYC - 1));

  // Serial clock low-time counter
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      low_cnt_reg <= 16'h0000;
    else if (sync2_reg[3])
      low_cnt_reg <= 16'h0000;
    else if (!low_hit)
      low_cnt_reg <= low_cnt_reg + 16'h0001;
  end

  assign fault_act = (state_reg == vcfd_pkg::VCFD_ACTIVE) && (fault_s != 3'h0);
  assign wr_ok     = bus.wr && (state_reg != vcfd_pkg::VCFD_SHUTDOWN);
  assign srst_req  = wr_ok && (bus.addr == `VCFD_OFS_CONTROL) && bus.wdata[`VCFD_CTL_SRST_BIT];
  assign load_def  = ((state_reg == vcfd_pkg::VCFD_SHUTDOWN) && scl_rise) || srst_req;

  // Power state sequencing
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= vcfd_pkg::VCFD_STANDBY;
    else if (low_hit)
      state_reg <= vcfd_pkg::VCFD_SHUTDOWN;
    else if (state_reg == vcfd_pkg::VCFD_SHUTDOWN)
    begin
      if (scl_rise)
        state_reg <= vcfd_pkg::VCFD_STANDBY;
    end
    else if (fault_act || srst_req)
      state_reg <= vcfd_pkg::VCFD_STANDBY;
    else if (code_reg != 10'h000)
      state_reg <= vcfd_pkg::VCFD_ACTIVE;
    else
      state_reg <= vcfd_pkg::VCFD_STANDBY;
  end

  // Configuration registers
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      code_reg    <= `VCFD_DEF_CODE;
      res_reg     <= `VCFD_DEF_RES;
      rate_reg    <= `VCFD_DEF_RATE;
      pwm_sel_reg <= `VCFD_DEF_PWM;
      onep_reg    <= `VCFD_DEF_ONEP;
    end
    else if (load_def)
    begin
      code_reg    <= `VCFD_DEF_CODE;
      res_reg     <= `VCFD_DEF_RES;
      rate_reg    <= `VCFD_DEF_RATE;
      pwm_sel_reg <= `VCFD_DEF_PWM;
      onep_reg    <= `VCFD_DEF_ONEP;
    end
    else if (fault_act)
      code_reg <= `VCFD_DEF_CODE;
    else if (wr_ok)
    begin
      case (bus.addr)
        `VCFD_OFS_CONTROL: rate_reg <= bus.wdata[`VCFD_CTL_RATE_MSB:`VCFD_CTL_RATE_LSB];
        `VCFD_OFS_MODE:
        begin
          pwm_sel_reg <= bus.wdata[`VCFD_MODE_PWM_BIT];
          onep_reg    <= bus.wdata[`VCFD_MODE_ONEP_BIT];
        end
        `VCFD_OFS_CODE: code_reg <= bus.wdata[9:0];
        `VCFD_OFS_RES: res_reg <= bus.wdata[7:0];
        default: ;
      endcase
    end
  end

  // Sticky fault flags, cleared on entry to active; a new fault wins
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      status_reg <= 3'h0;
    else if (state_reg != vcfd_pkg::VCFD_ACTIVE && code_reg != 10'h000 && !load_def)
      status_reg <= fault_s;
    else
      status_reg <= status_reg | fault_s;
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      rd_data_reg <= 16'h0000;
    else if (!bus.rd)
      rd_data_reg <= 16'h0000;
    else
      case (bus.addr)
        `VCFD_OFS_CONTROL: rd_data_reg <= {12'h000, rate_reg, 1'b0};
        `VCFD_OFS_MODE:    rd_data_reg <= {14'h0000, onep_reg, pwm_sel_reg};
        `VCFD_OFS_CODE:    rd_data_reg <= {6'h00, code_reg};
        `VCFD_OFS_STATUS:  rd_data_reg <= {11'h000, state_reg, status_reg};
        `VCFD_OFS_RES:     rd_data_reg <= {8'h00, res_reg};
        default:           rd_data_reg <= 16'h0000;
      endcase
  end

  // Ramp step length from the resonance setting; two periods doubles it
  always_comb
  begin
    step_len = 18'(RAMP_STEP_MAX) - 18'(res_reg * RAMP_SLOPE);
    if (!onep_reg)
      step_len = {step_len[16:0], 1'b0};
    if (step_len == 18'h00000)
      step_len = 18'h00001;
  end
  assign ramp_new   = (code_reg != target_reg);
  assign drive_next = 10'($signed({7'h00, start_reg})
                    + ((($signed({7'h00, target_reg}) - $signed({7'h00, start_reg}))
                    * $signed({12'h000, idx_reg})) >>> `VCFD_RAMP_SHIFT));

  // Ringing-compensating ramp toward the written code
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      start_reg  <= 10'h000;
      target_reg <= 10'h000;
      idx_reg    <= `VCFD_RAMP_LAST;
      tick_reg   <= 18'h00000;
    end
    else if (ramp_new)
    begin
      start_reg  <= drive_reg;
      target_reg <= code_reg;
      idx_reg    <= 5'h00;
      tick_reg   <= 18'h00000;
    end
    else if (idx_reg != `VCFD_RAMP_LAST)
    begin
      if (tick_reg >= step_len - 18'h00001)
      begin
        tick_reg <= 18'h00000;
        idx_reg  <= idx_reg + 5'h01;
      end
      else
        tick_reg <= tick_reg + 18'h00001;
    end
  end
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      drive_reg <= 10'h000;
    else if (!ramp_new)
      drive_reg <= drive_next;
  end

  // PWM period counter and switching-rate table
  assign period   = 6'(`VCFD_CLK_KHZ / (`VCFD_PWM_MIN_KHZ * ({29'h0, rate_reg} + 32'h1)));
  assign pwm_wrap = (pwm_cnt_reg >= period - 6'h01);
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pwm_cnt_reg <= 6'h00;
      on_cnt_reg  <= 6'h00;
      pwm_lat_reg <= 1'b0;
      lin_reg     <= 1'b1;
    end
    else if (pwm_wrap)
    begin
      pwm_cnt_reg <= 6'h00;
      on_cnt_reg  <= 6'(({6'h00, drive_reg} * {10'h000, period}) >> `VCFD_CODE_SHIFT);
      pwm_lat_reg <= pwm_sel_reg;
      lin_reg     <= !pwm_sel_reg;
    end
    else
      pwm_cnt_reg <= pwm_cnt_reg + 6'h01;
  end

  // Output stage gates
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage_en_reg <= 1'b0;
      hs_reg       <= 1'b0;
      ls_reg       <= 1'b0;
    end
    else
    begin
      stage_en_reg <= (state_reg == vcfd_pkg::VCFD_ACTIVE);
      if (state_reg != vcfd_pkg::VCFD_ACTIVE)
      begin
        hs_reg <= 1'b0;
        ls_reg <= 1'b0;
      end
      else if (!pwm_lat_reg)
      begin
        hs_reg <= 1'b1;
        ls_reg <= 1'b0;
      end
      else
      begin
        hs_reg <= (pwm_cnt_reg < on_cnt_reg);
        ls_reg <= (pwm_cnt_reg >= on_cnt_reg);
      end
    end
  end

  assign rd_data       = rd_data_reg;
  assign coil_dac_code = drive_reg;
  assign stage_en      = stage_en_reg;
  assign hs_gate       = hs_reg;
  assign ls_gate       = ls_reg;
  assign lin_drive     = lin_reg;
  assign power_state   = state_reg;

  property p_timeout;
    @(posedge mclk) disable iff (!arst_n) low_hit |=> state_reg == vcfd_pkg::VCFD_SHUTDOWN;
  endproperty
  a_timeout: assert property (p_timeout) else $error("no shutdown after clock low");
  property p_wake;
    @(posedge mclk) disable iff (!arst_n)
      (state_reg == vcfd_pkg::VCFD_SHUTDOWN && scl_rise && !low_hit)
      |=> (state_reg == vcfd_pkg::VCFD_STANDBY && code_reg == `VCFD_DEF_CODE && res_reg == `VCFD_DEF_RES);
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not give standby defaults");
  property p_active;
    @(posedge mclk) disable iff (!arst_n)
      (state_reg == vcfd_pkg::VCFD_STANDBY && code_reg != 10'h000 && !low_hit && !fault_act && !srst_req)
      |=> state_reg == vcfd_pkg::VCFD_ACTIVE ##1 stage_en;
  endproperty
  a_active: assert property (p_active) else $error("nonzero code not active");
  property p_ramp_restart;
    @(posedge mclk) disable iff (!arst_n)
      ramp_new |=> (idx_reg == 5'h00 && start_reg == $past(drive_reg) && drive_reg == $past(drive_reg));
  endproperty
  a_ramp_restart: assert property (p_ramp_restart) else $error("ramp did not restart at present current");
  property p_ramp_hold;
    @(posedge mclk) disable iff (!arst_n)
      (!ramp_new && idx_reg != `VCFD_RAMP_LAST && tick_reg < step_len - 18'h00001) ##1 !ramp_new
      |-> $stable(idx_reg);
  endproperty
  a_ramp_hold: assert property (p_ramp_hold) else $error("ramp stepped early");
  property p_linear;
    @(posedge mclk) disable iff (!arst_n)
      (state_reg == vcfd_pkg::VCFD_ACTIVE && !pwm_lat_reg) |=> (hs_gate && !ls_gate);
  endproperty
  a_linear: assert property (p_linear) else $error("linear drive not current source");
  property p_pwm_order;
    @(posedge mclk) disable iff (!arst_n)
      !(hs_gate && ls_gate) and ((ls_gate ##1 hs_gate) |-> $past(pwm_cnt_reg) == 6'h00);
  endproperty
  a_pwm_order: assert property (p_pwm_order) else $error("PWM phase order broken");
  property p_mode_edge;
    @(posedge mclk) disable iff (!arst_n) $changed(pwm_lat_reg) |-> pwm_cnt_reg == 6'h00;
  endproperty
  a_mode_edge: assert property (p_mode_edge) else $error("drive style changed mid period");
  property p_fault;
    @(posedge mclk) disable iff (!arst_n)
      (fault_act && !low_hit) |=> (state_reg == vcfd_pkg::VCFD_STANDBY && code_reg == 10'h000);
  endproperty
  a_fault: assert property (p_fault) else $error("fault did not drop to standby");
  property p_srst;
    @(posedge mclk) disable iff (!arst_n)
      (srst_req && state_reg == vcfd_pkg::VCFD_ACTIVE && !low_hit)
      |=> (state_reg == vcfd_pkg::VCFD_STANDBY && rate_reg == `VCFD_DEF_RATE && code_reg == 10'h000);
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset not applied");
  property p_res_read;
    @(posedge mclk) disable iff (!arst_n)
      (bus.rd && bus.addr == `VCFD_OFS_RES) |=> rd_data == {8'h00, $past(res_reg)};
  endproperty
  a_res_read: assert property (p_res_read) else $error("resonance read wrong");

endmodule // vcfd_ctrl

// >>> dv/vcfd_scl_host.sv
// Serial clock line of the link host, for the focus driver bench
`timescale 1ns/1ps

module vcfd_scl_host (
  input  wire logic hold_low,
  input  wire logic run,
  output logic      scl
);
  initial
  begin
    scl = 1'b1;
    forever
    begin
      if (run)
      begin
        scl = 1'b0;
        #160;
        scl = 1'b1;
        #160;
      end
      else
      begin
        scl = !hold_low; // Pull-up when released
        @(hold_low or run);
        #7;
      end
    end
  end
endmodule // vcfd_scl_host

// >>> dv/vcfd_ctrl_tb_top.sv
// Testbench of the voice-coil focus driver control block
`timescale 1ns/1ps
`include "vcfd_defines.svh"

module vcfd_ctrl_tb_top;
  logic                  mclk;
  logic                  arst_n;
  logic                  scl;
  logic                  scl_low;
  logic                  scl_run;
  vcfd_pkg::vcfd_bus_t   bus;
  vcfd_pkg::vcfd_fault_t faults;
  logic [15:0]           rd_data;
  logic [9:0]            coil_dac_code;
  logic                  stage_en;
  logic                  hs_gate;
  logic                  ls_gate;
  logic                  lin_drive;
  vcfd_pkg::vcfd_state_t power_state;
  int                    failures;
  int                    cmp_count;
  int                    n;
  int                    hi;
  int                    per;
  int                    bad;
  int                    p;

  vcfd_ctrl #(.CLK_LOW_CYC(20), .RAMP_STEP_MAX(8), .RAMP_SLOPE(0)) i_dut (
    .mclk          (mclk),
    .arst_n        (arst_n),
    .scl_in        (scl),
    .bus           (bus),
    .faults        (faults),
    .rd_data       (rd_data),
    .coil_dac_code (coil_dac_code),
    .stage_en      (stage_en),
    .hs_gate       (hs_gate),
    .ls_gate       (ls_gate),
    .lin_drive     (lin_drive),
    .power_state   (power_state)
  );

  vcfd_scl_host i_host (
    .hold_low (scl_low),
    .run      (scl_run),
    .scl      (scl)
  );

  task automatic report_and_stop();
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(negedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    @(negedge mclk);
    chk("rd_data", e, rd_data);
  endtask

  task automatic stc(input vcfd_pkg::vcfd_state_t e);
    chk("power_state", {14'h0, e}, {14'h0, power_state});
  endtask

  task automatic ramp(input logic [9:0] c);
    wr(`VCFD_OFS_CODE, {6'h0, c});
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (coil_dac_code !== c && n < 2000);
  endtask

  // One PWM period: high-side time, full period, freewheel faults
  task automatic pwm();
    n = 0;
    while (hs_gate !== 1'b0 && n < 200)
    begin
      @(negedge mclk);
      n++;
    end
    while (hs_gate !== 1'b1 && n < 200)
    begin
      @(negedge mclk);
      n++;
    end
    hi = 0;
    per = 0;
    bad = 0;
    while (hs_gate === 1'b1 && per < 200)
    begin
      @(negedge mclk);
      hi++;
      per++;
    end
    while (hs_gate !== 1'b1 && per < 200)
    begin
      if (ls_gate !== 1'b1)
        bad++;
      @(negedge mclk);
      per++;
    end
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial
  begin
    #2000000;
    failures++;
    report_and_stop();
  end

  initial
  begin
    arst_n = 1'b0;
    scl_low = 1'b0;
    scl_run = 1'b0;
    bus = '0;
    faults = '0;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    cyc(1);
    stc(vcfd_pkg::VCFD_STANDBY);
    chk("lin_drive", 16'h1, {15'h0, lin_drive});
    rdc(`VCFD_OFS_RES, 16'h0);
    rdc(`VCFD_OFS_CODE, 16'h0);
    rdc(8'h10, 16'h0);
    wr(`VCFD_OFS_RES, 16'h12a5);
    rdc(`VCFD_OFS_RES, 16'h00a5);
    wr(`VCFD_OFS_CODE, 16'h0100);
    cyc(3);
    stc(vcfd_pkg::VCFD_ACTIVE);
    chk("stage_en", 16'h1, {15'h0, stage_en});
    cyc(60);
    chk("coil_dac_code", 16'h1, {15'h0, coil_dac_code > 0 && coil_dac_code < 10'h100});
    cyc(300);
    chk("coil_dac_code", 16'h0100, {6'h0, coil_dac_code});
    ramp(10'h200);
    chk("ramp_len", 16'h1, {15'h0, n >= 250 && n <= 262});
    wr(`VCFD_OFS_MODE, 16'h0002);
    ramp(10'h100);
    chk("ramp_len", 16'h1, {15'h0, n >= 122 && n <= 134});
    wr(`VCFD_OFS_MODE, 16'h0000);
    wr(`VCFD_OFS_CODE, 16'h0300);
    cyc(64);
    wr(`VCFD_OFS_CODE, 16'h0200);
    cyc(2);
    chk("coil_dac_code", 16'h1, {15'h0, coil_dac_code > 10'h100 && coil_dac_code <= 10'h200});
    cyc(300);
    chk("coil_dac_code", 16'h0200, {6'h0, coil_dac_code});
    wr(`VCFD_OFS_MODE, 16'h0001);
    for (int s = 0; s < 8; s++)
    begin
      wr(`VCFD_OFS_CONTROL, {12'h0, 3'(s), 1'b0});
      cyc(120);
      pwm();
      p = 25000 / (500 * (s + 1));
      chk("pwm_period", 16'(p), 16'(per));
      chk("hs_on", 16'((512 * p) >> 10), 16'(hi));
      chk("freewheel", 16'h0, 16'(bad));
    end
    chk("lin_drive", 16'h0, {15'h0, lin_drive});
    chk("coil_dac_code", 16'h0200, {6'h0, coil_dac_code});
    wr(`VCFD_OFS_MODE, 16'h0000);
    cyc(120);
    chk("lin_drive", 16'h1, {15'h0, lin_drive});
    chk("coil_dac_code", 16'h0200, {6'h0, coil_dac_code});
    for (int i = 0; i < 3; i++)
    begin
      wr(`VCFD_OFS_CODE, 16'h0100);
      cyc(4);
      stc(vcfd_pkg::VCFD_ACTIVE);
      @(posedge mclk);
      faults <= 3'(1 << i);
      cyc(5);
      stc(vcfd_pkg::VCFD_STANDBY);
      rdc(`VCFD_OFS_CODE, 16'h0);
      rdc(`VCFD_OFS_STATUS, 16'h0008 | 16'(1 << i));
      @(posedge mclk);
      faults <= '0;
      cyc(3);
    end
    wr(`VCFD_OFS_RES, 16'h0033);
    wr(`VCFD_OFS_MODE, 16'h0003);
    wr(`VCFD_OFS_CODE, 16'h0100);
    cyc(4);
    stc(vcfd_pkg::VCFD_ACTIVE);
    wr(`VCFD_OFS_CONTROL, 16'h0001);
    cyc(3);
    stc(vcfd_pkg::VCFD_STANDBY);
    rdc(`VCFD_OFS_RES, 16'h0);
    rdc(`VCFD_OFS_MODE, 16'h0);
    rdc(`VCFD_OFS_CODE, 16'h0);
    rdc(`VCFD_OFS_CONTROL, 16'h0);
    wr(`VCFD_OFS_RES, 16'h0044);
    @(posedge mclk);
    scl_low <= 1'b1;
    cyc(15);
    stc(vcfd_pkg::VCFD_STANDBY);
    cyc(15);
    stc(vcfd_pkg::VCFD_SHUTDOWN);
    wr(`VCFD_OFS_RES, 16'h0055);
    @(posedge mclk);
    scl_low <= 1'b0;
    scl_run <= 1'b1;
    cyc(12);
    stc(vcfd_pkg::VCFD_STANDBY);
    rdc(`VCFD_OFS_RES, 16'h0);
    report_and_stop();
  end
endmodule // vcfd_ctrl_tb_top
